// *** rtl/lcd_fb_pkg.sv ***
// Register map, field layout and carrier types of the frame-address block
package lcd_fb_pkg;
  localparam logic [31:0] OFS_PANEL_CTRL = 32'h4D00_0000;
  localparam logic [31:0] OFS_OUT_CTRL   = 32'h4D00_0010;
  localparam logic [31:0] OFS_BANK_UPPER = 32'h4D00_0014;
  localparam logic [31:0] OFS_LOWER_END  = 32'h4D00_0018;
  localparam logic [31:0] OFS_GEOMETRY   = 32'h4D00_001C;
  localparam logic [31:0] OFS_RED_LUT    = 32'h4D00_0020;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  // Output control fields
  localparam int BIT_DE_INV    = 6;
  localparam int BIT_PWR_INV   = 5;
  localparam int BIT_LINE_END_OUT_INV  = 4;
  localparam int BIT_PWR_EN    = 3;
  localparam int BIT_LINE_END_OUT_EN   = 2;
  localparam int BIT_BYTE_SWP  = 1;
  localparam int BIT_HALF_SWP  = 0;
  localparam logic [31:0] OUT_CTRL_MASK = 32'h0000_007F;
  // Panel control fields
  localparam int BIT_VIDEO_ON  = 0;
  localparam int BIT_DUAL_SCAN = 1;
  localparam int BIT_PASSIVE   = 2;
  localparam int LINES_LSB     = 8;
  localparam int LINES_W       = 10;
  localparam int CUR_LINE_LSB  = 18;
  localparam logic [31:0] PANEL_CTRL_MASK = 32'h0003_FF07;
  // Address fields
  localparam int BANK_LSB  = 21;
  localparam int BANK_W    = 9;
  localparam int BASE_W    = 21;
  localparam int SKIP_LSB  = 11;
  localparam int GEOM_W    = 11;
  localparam logic [31:0] BANK_UPPER_MASK = 32'h3FFF_FFFF;
  localparam logic [31:0] BASE_MASK       = 32'h001F_FFFF;
  localparam logic [31:0] GEOM_MASK       = 32'h003F_FFFF;
  localparam logic [BASE_W-1:0] WORD_HALVES = 21'h00_0002;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Link side
  localparam int FIFO_DEPTH = 16;
  typedef struct packed {
    logic        line_end;
    logic [31:0] data;
  } fetch_word_t;
  localparam int WORD_W = $bits(fetch_word_t);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_DONE = 3'b100
  } fetch_state_t;
endpackage : lcd_fb_pkg

// *** rtl/lcd_word_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module lcd_word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lcd_word_fifo

// *** rtl/lcd_frame_addr.sv ***
// Frame-buffer address generation and panel output control
//
// Summary of operation
// R1 - Data enable inverted by its polarity bit outside passive mode
// R2 - Power enable polarity from its bit; here a set bit holds the output low instead of inverting it
// R3 - Line end inverted by its polarity bit outside passive mode
// R4 - Power enable output held off unless enabled
// R5 - Line end output gated by its enable
// R6 - Byte swap of fetched words when set
// R7 - Half-word swap of fetched words when set
// R8 - Bank field drives fetch address 30:22
// R9 - Upper base starts upper address counter
// R10 - Lower base starts lower counter, dual scan
// R11 - Software loads frame end in single scan
// R12 - Bases may change live, latched per frame
// R13 - Software masks interrupts around line reads
// R14 - Skip size spans line end to next
// R15 - Viewport width counts half-words per line
// R16 - Geometry changed only with video off
// R17 - Red code selects 4-bit table field
// R18 - Advance by skip, stop at lower base
// R19 - Byte swap first, then half-word swap
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module lcd_frame_addr
  import lcd_fb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Video fetch port
  output logic             fetch_req,
  output logic [31:0]      fetch_addr,
  input  wire logic        fetch_ack,
  input  wire logic [31:0] fetch_data,
  // Panel link
  input  wire logic        pix_clk_in,
  output logic [31:0]      panel_data,
  output logic [3:0]       red_shade,
  output logic             data_enable_out,
  output logic             line_end_out,
  output logic             panel_power_out
);
  // Register state
  logic [31:0] panel_ctrl_q, out_ctrl_q, bank_upper_q;
  logic [31:0] lower_end_q, geometry_q, red_lut_q;
  logic        aw_rdy_q, w_rdy_q, b_vld_q, ar_rdy_q, r_vld_q;
  logic [1:0]  b_resp_q, r_resp_q;
  logic [31:0] r_data_q;
  // Field views
  logic              video_output_on, dual_scan, passive_mode;
  logic [LINES_W-1:0] line_count_setting;
  logic [BANK_W-1:0] frame_bank;
  logic [BASE_W-1:0] upper_base, lower_base;
  logic [GEOM_W-1:0] line_skip_size, viewport_width;
  logic data_enable_invert, power_enable_invert, line_end_invert;
  logic panel_power_enable, line_end_output_on, byte_swap_on, halfword_swap_on;

  assign video_output_on     = panel_ctrl_q[BIT_VIDEO_ON];
  assign dual_scan           = panel_ctrl_q[BIT_DUAL_SCAN];
  assign passive_mode        = panel_ctrl_q[BIT_PASSIVE];
  assign line_count_setting  = panel_ctrl_q[LINES_LSB +: LINES_W];
  assign frame_bank          = bank_upper_q[BANK_LSB +: BANK_W];
  assign upper_base          = bank_upper_q[BASE_W-1:0];
  assign lower_base          = lower_end_q[BASE_W-1:0];
  assign line_skip_size      = geometry_q[SKIP_LSB +: GEOM_W];
  assign viewport_width      = geometry_q[GEOM_W-1:0];
  assign data_enable_invert  = out_ctrl_q[BIT_DE_INV];
  assign power_enable_invert = out_ctrl_q[BIT_PWR_INV];
  assign line_end_invert     = out_ctrl_q[BIT_LINE_END_OUT_INV];
  assign panel_power_enable  = out_ctrl_q[BIT_PWR_EN];
  assign line_end_output_on  = out_ctrl_q[BIT_LINE_END_OUT_EN];
  assign byte_swap_on        = out_ctrl_q[BIT_BYTE_SWP];
  assign halfword_swap_on    = out_ctrl_q[BIT_HALF_SWP];

  // Word merge under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r & msk;
  endfunction : merge

  // Byte then half-word swap
  function automatic logic [31:0] swap_word(input logic [31:0] w, input logic bs,
                                            input logic hs);
    logic [31:0] r;
    r = bs ? {w[23:16], w[31:24], w[7:0], w[15:8]} : w;  // R6 R19
    r = hs ? {r[15:0], r[31:16]} : r;                    // R7 R19
    return r;
  endfunction : swap_word

  // Write channel
  logic wr_go, wr_hit;
  assign wr_go = aw_rdy_q & s_axi_awvalid & w_rdy_q & s_axi_wvalid;
  assign wr_hit = (s_axi_awaddr == OFS_PANEL_CTRL) || (s_axi_awaddr == OFS_OUT_CTRL) ||
                  (s_axi_awaddr == OFS_BANK_UPPER) || (s_axi_awaddr == OFS_LOWER_END) ||
                  (s_axi_awaddr == OFS_GEOMETRY)   || (s_axi_awaddr == OFS_RED_LUT);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_rdy_q <= 1'b0;
      w_rdy_q  <= 1'b0;
      b_vld_q  <= 1'b0;
      b_resp_q <= RESP_OKAY;
    end else if (wr_go) begin
      aw_rdy_q <= 1'b0;
      w_rdy_q  <= 1'b0;
      b_vld_q  <= 1'b1;
      b_resp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (b_vld_q) begin
      b_vld_q <= !s_axi_bready;
    end else begin
      aw_rdy_q <= s_axi_awvalid & s_axi_wvalid & !aw_rdy_q;
      w_rdy_q  <= s_axi_awvalid & s_axi_wvalid & !w_rdy_q;
    end
  end

  // Register writes; bases and geometry apply at next frame start
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      panel_ctrl_q <= RST_WORD;
      out_ctrl_q   <= RST_WORD;
      bank_upper_q <= RST_WORD;
      lower_end_q  <= RST_WORD;
      geometry_q   <= RST_WORD;
      red_lut_q    <= RST_WORD;
    end else if (wr_go) begin
      if (s_axi_awaddr == OFS_PANEL_CTRL) begin
        panel_ctrl_q <= merge(panel_ctrl_q, s_axi_wdata, s_axi_wstrb, PANEL_CTRL_MASK);
      end else if (s_axi_awaddr == OFS_OUT_CTRL) begin
        out_ctrl_q <= merge(out_ctrl_q, s_axi_wdata, s_axi_wstrb, OUT_CTRL_MASK);
      end else if (s_axi_awaddr == OFS_BANK_UPPER) begin
        bank_upper_q <= merge(bank_upper_q, s_axi_wdata, s_axi_wstrb, BANK_UPPER_MASK); // R12
      end else if (s_axi_awaddr == OFS_LOWER_END) begin
        lower_end_q <= merge(lower_end_q, s_axi_wdata, s_axi_wstrb, BASE_MASK); // R12
      end else if (s_axi_awaddr == OFS_GEOMETRY) begin
        geometry_q <= merge(geometry_q, s_axi_wdata, s_axi_wstrb, GEOM_MASK);
      end else if (s_axi_awaddr == OFS_RED_LUT) begin
        red_lut_q <= merge(red_lut_q, s_axi_wdata, s_axi_wstrb, 32'hFFFF_FFFF);
      end
    end
  end

  // Read channel
  logic [LINES_W-1:0] cur_line_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ar_rdy_q <= 1'b0;
      r_vld_q  <= 1'b0;
      r_data_q <= RST_WORD;
      r_resp_q <= RESP_OKAY;
    end else if (ar_rdy_q && s_axi_arvalid) begin
      ar_rdy_q <= 1'b0;
      r_vld_q  <= 1'b1;
      r_resp_q <= RESP_OKAY;
      if (s_axi_araddr == OFS_PANEL_CTRL) begin
        r_data_q <= panel_ctrl_q | (32'(cur_line_q) << CUR_LINE_LSB);
      end else if (s_axi_araddr == OFS_OUT_CTRL) begin
        r_data_q <= out_ctrl_q;
      end else if (s_axi_araddr == OFS_BANK_UPPER) begin
        r_data_q <= bank_upper_q;
      end else if (s_axi_araddr == OFS_LOWER_END) begin
        r_data_q <= lower_end_q;
      end else if (s_axi_araddr == OFS_GEOMETRY) begin
        r_data_q <= geometry_q;
      end else if (s_axi_araddr == OFS_RED_LUT) begin
        r_data_q <= red_lut_q;
      end else begin
        r_data_q <= RST_WORD;
        r_resp_q <= RESP_SLVERR;
      end
    end else if (r_vld_q) begin
      r_vld_q <= !s_axi_rready;
    end else begin
      ar_rdy_q <= s_axi_arvalid & !ar_rdy_q;
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = w_rdy_q;
  assign s_axi_bvalid  = b_vld_q;
  assign s_axi_bresp   = b_resp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = r_vld_q;
  assign s_axi_rdata   = r_data_q;
  assign s_axi_rresp   = r_resp_q;

  // Fetch engine
  fetch_state_t      st_q;
  logic [BASE_W-1:0] up_ptr_q, lo_ptr_q, end_q, ptr, ptr_nx;
  logic [GEOM_W-1:0] col_q, width_q, skip_q;
  logic              half_q, dual_q, req_q;
  logic [31:0]       addr_q;
  logic              fifo_in_ready, eol, last;
  fetch_word_t       push_word;

  assign ptr    = half_q ? lo_ptr_q : up_ptr_q;
  assign eol    = ({1'b0, col_q} + 12'h002) >= {1'b0, width_q};             // R15
  assign ptr_nx = ptr + WORD_HALVES + (eol ? BASE_W'(skip_q) : '0);         // R14 R18
  assign last   = eol && (dual_q ? (half_q && cur_line_q == line_count_setting)
                                 : (ptr_nx >= end_q));                     // R18
  assign push_word.line_end = eol;
  assign push_word.data     = swap_word(fetch_data, byte_swap_on, halfword_swap_on);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      up_ptr_q   <= '0;
      lo_ptr_q   <= '0;
      end_q      <= '0;
      width_q    <= '0;
      skip_q     <= '0;
      col_q      <= '0;
      half_q     <= 1'b0;
      dual_q     <= 1'b0;
      cur_line_q <= '0;
      req_q      <= 1'b0;
      addr_q     <= RST_WORD;
    end else begin
      case (st_q)
        ST_IDLE: begin
          up_ptr_q   <= upper_base;                                 // R9 R12
          lo_ptr_q   <= lower_base;                                 // R10
          end_q      <= lower_base;                                 // R18
          width_q    <= viewport_width;                             // R15
          skip_q     <= line_skip_size;                             // R14
          dual_q     <= dual_scan;
          col_q      <= '0;
          half_q     <= 1'b0;
          cur_line_q <= '0;
          if (video_output_on) begin
            st_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (req_q && fetch_ack) begin
            req_q <= 1'b0;
            col_q <= eol ? '0 : col_q + 11'h002;
            if (half_q) begin
              lo_ptr_q <= ptr_nx;
            end else begin
              up_ptr_q <= ptr_nx;
            end
            if (eol && dual_q) begin
              half_q <= !half_q;
            end
            if (eol && (!dual_q || half_q) && !last) begin
              cur_line_q <= cur_line_q + 1'b1;
            end
            if (last) begin
              st_q <= ST_DONE;
            end
          end else if (!req_q && !video_output_on) begin
            st_q <= ST_IDLE;
          end else if (!req_q && fifo_in_ready) begin
            req_q  <= 1'b1;
            addr_q <= {1'b0, frame_bank, ptr, 1'b0};               // R8
          end
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign fetch_req  = req_q;
  assign fetch_addr = addr_q;

  // Word buffer between fetch and panel
  logic        fifo_out_valid, pix_pop;
  fetch_word_t pop_word;
  lcd_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (req_q & fetch_ack),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (pix_pop),
    .out_data  (pop_word)
  );

  // Pixel clock sampling and edge detection
  logic pix_s1_q, pix_s2_q, pix_s3_q, pix_rise;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pix_s1_q <= 1'b0;
      pix_s2_q <= 1'b0;
      pix_s3_q <= 1'b0;
    end else begin
      pix_s1_q <= pix_clk_in;
      pix_s2_q <= pix_s1_q;
      pix_s3_q <= pix_s2_q;
    end
  end
  assign pix_rise = pix_s2_q & !pix_s3_q;
  assign pix_pop  = pix_rise & fifo_out_valid;

  // Panel outputs
  logic [31:0] pdata_q;
  logic [3:0]  shade_q;
  logic        de_raw_q, line_end_out_raw_q, de_q, line_end_out_q, pwr_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pdata_q    <= RST_WORD;
      shade_q    <= 4'h0;
      de_raw_q   <= 1'b0;
      line_end_out_raw_q <= 1'b0;
    end else begin
      if (pix_rise) begin
        de_raw_q   <= fifo_out_valid;
        line_end_out_raw_q <= fifo_out_valid & pop_word.line_end;
      end
      if (pix_pop) begin
        pdata_q <= pop_word.data;
      end
      if (!passive_mode) begin
        shade_q <= 4'h0;
      end else if (pix_pop) begin
        shade_q <= red_lut_q[{pop_word.data[2:0], 2'b00} +: 4];     // R17
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      de_q   <= 1'b0;
      line_end_out_q <= 1'b0;
      pwr_q  <= 1'b0;
    end else begin
      de_q   <= de_raw_q ^ (data_enable_invert & !passive_mode);              // R1
      line_end_out_q <= line_end_output_on &&
                (line_end_out_raw_q ^ (line_end_invert & !passive_mode));            // R3 R5
      pwr_q  <= panel_power_enable & !power_enable_invert;                   // R2 R4
    end
  end

  assign panel_data      = pdata_q;
  assign red_shade       = shade_q;
  assign data_enable_out = de_q;
  assign line_end_out    = line_end_out_q;
  assign panel_power_out = pwr_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_DE_POL: assert property (de_q == $past(de_raw_q ^ (data_enable_invert & !passive_mode))) // R1
    else $error("data enable polarity wrong");
  AST_PWR_OFF: assert property (!$past(panel_power_enable) |-> !pwr_q) // R4
    else $error("power enable active while disabled");
  AST_PWR_POL: assert property ($past(panel_power_enable) |->
                                pwr_q == !$past(power_enable_invert)) // R2
    else $error("power enable polarity wrong");
  AST_LINE_END_OUT_OFF: assert property (!$past(line_end_output_on) |-> !line_end_out_q) // R5
    else $error("line end driven while disabled");
  AST_LINE_END_OUT_POL: assert property ($past(line_end_output_on) && !$past(passive_mode) |->
                                 line_end_out_q == ($past(line_end_out_raw_q) ^ $past(line_end_invert))) // R3
    else $error("line end polarity wrong");
  AST_BANK: assert property ($rose(req_q) |-> addr_q[30:22] == frame_bank && !addr_q[0]) // R8
    else $error("fetch bank bits wrong");
  AST_SWAP: assert property (req_q && fetch_ack && byte_swap_on && !halfword_swap_on |->
                             push_word.data[31:24] == fetch_data[23:16]) // R6
    else $error("byte swap missing");
  AST_HSWAP: assert property (req_q && fetch_ack && halfword_swap_on && !byte_swap_on |->
                              push_word.data == {fetch_data[15:0], fetch_data[31:16]}) // R7 with byte swap off
    else $error("half-word swap missing");
  sequence s_frame_start;
    st_q == ST_IDLE && video_output_on;
  endsequence
  AST_START: assert property (s_frame_start |=> up_ptr_q == $past(upper_base)) // R9
    else $error("upper counter not loaded");
  AST_STOP: assert property (req_q && fetch_ack && !dual_q && eol && ptr_nx >= end_q |=>
                             st_q == ST_DONE ##1 st_q == ST_IDLE) // R18
    else $error("frame did not stop at lower base");
  AST_SHADE: assert property (pix_pop && passive_mode |=>
                              red_shade == red_lut_q[{pdata_q[2:0], 2'b00} +: 4]) // R17
    else $error("red shade lookup wrong");
endmodule : lcd_frame_addr

// *** bench/lcd_panel_model.sv ***
// Panel-side model: pixel clock source and frame memory responder
`timescale 1ns/1ps
module lcd_panel_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Bench control
  input  wire logic        run,
  input  wire logic [31:0] mem_word,
  // Fetch port
  input  wire logic        fetch_req,
  output logic             fetch_ack,
  output logic [31:0]      fetch_data,
  // Panel link
  output logic             pix_clk_in
);
  // Pixel clock, 160 ns, off-phase to clk_sys, idle low while run is low
  initial begin
    pix_clk_in = 1'b0;
    #1.3;
    forever begin
      #80;
      pix_clk_in = run ? ~pix_clk_in : 1'b0;
    end
  end

  // Memory answers promptly or after random stalls
  always_ff @(posedge clk_sys) begin
    if (!rst_n) fetch_ack <= 1'b0;
    else fetch_ack <= fetch_req && !fetch_ack && ($urandom_range(2) == 0);
  end

  // Data bus shows garbage while no word is offered
  assign fetch_data = fetch_ack ? mem_word : ~mem_word;
endmodule : lcd_panel_model

// *** bench/test_lcd_frame_addr.sv ***
// Self-checking bench of the frame-address and output-control block
`timescale 1ns/1ps
module test_lcd_frame_addr import lcd_fb_pkg::*; ;
  localparam int W = 8;
  localparam int S = 2;
  localparam int LINES = 3;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, fetch_addr, fetch_data, panel_data, v, lut;
  logic [31:0] mem_word = 32'h0;
  logic        fetch_req, fetch_ack, pix_clk_in, data_enable_out, line_end_out;
  logic        panel_power_out;
  logic        run = 1'b0;
  logic        mon_on = 1'b0;
  logic [3:0]  red_shade;
  logic [6:0]  ctl;
  logic [8:0]  bank;
  logic [20:0] upper, lower, ptr, ptl;
  logic        half = 1'b0;
  logic        dual = 1'b0;
  logic [31:0] ofs [5] = '{OFS_OUT_CTRL, OFS_BANK_UPPER, OFS_LOWER_END, OFS_GEOMETRY,
                           OFS_RED_LUT};
  logic [31:0] msk [5] = '{OUT_CTRL_MASK, BANK_UPPER_MASK, BASE_MASK, GEOM_MASK,
                           32'hFFFF_FFFF};
  int          error_cnt = 0;
  int          checks = 0;
  int          col, hi, ln;

  always #2.5 clk_sys = ~clk_sys;

  lcd_frame_addr u_dut (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_addr, .fetch_ack,
    .fetch_data, .pix_clk_in, .panel_data, .red_shade, .data_enable_out,
    .line_end_out, .panel_power_out
  );

  lcd_panel_model u_panel (
    .clk_sys, .rst_n, .run, .mem_word, .fetch_req, .fetch_ack, .fetch_data, .pix_clk_in
  );

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_wr

  task axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : axi_rd

  function automatic logic [31:0] swp(input logic [31:0] d, input logic [1:0] s);
    logic [31:0] x;
    x = s[1] ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
    return s[0] ? {x[15:0], x[31:16]} : x;
  endfunction : swp

  // Expected fetch pointer walk across lines and frames
  always @(posedge clk_sys) begin
    if (mon_on && fetch_req && fetch_ack) begin
      chk(fetch_addr, {1'b0, bank, half ? ptl : ptr, 1'b0});
      if (half) ptl = ptl + 21'h2;
      else ptr = ptr + 21'h2;
      col = col + 2;
      if (col >= W) begin
        col = 0;
        if (half) ptl = ptl + 21'(S);
        else ptr = ptr + 21'(S);
        if (dual) begin
          ln = ln + int'(half);
          half = !half;
          if (ln == LINES) begin
            ln = 0;
            ptr = upper;
            ptl = lower;
          end
        end else if (ptr >= lower) begin
          ptr = upper;
        end
      end
    end
  end

  task complete_run;
    $display("Counts: checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hD36B));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(OFS_PANEL_CTRL, RST_WORD, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      v = $urandom;
      axi_rd(ofs[i], RST_WORD, RESP_OKAY);
      axi_wr(ofs[i], v, RESP_OKAY);
      axi_rd(ofs[i], v & msk[i], RESP_OKAY);
    end
    axi_wr(32'h4D00_0030, v, RESP_SLVERR);
    axi_rd(32'h4D00_0030, 32'h0, RESP_SLVERR);
    $display("Test registers done");
    // Frame inside one aligned region, end address from the geometry
    bank = 9'($urandom);
    upper = 21'($urandom) & 21'h0F_FFFE;
    lower = upper + 21'((W + S) * LINES);
    axi_wr(OFS_BANK_UPPER, {2'h0, bank, upper}, RESP_OKAY);
    axi_wr(OFS_LOWER_END, {11'h0, lower}, RESP_OKAY);
    axi_wr(OFS_GEOMETRY, {10'h0, 11'(S), 11'(W)}, RESP_OKAY);
    mem_word <= $urandom;
    ptr = upper;
    col = 0;
    mon_on = 1'b1;
    run <= 1'b1;
    axi_wr(OFS_PANEL_CTRL, 32'h0000_0001, RESP_OKAY);
    for (int k = 0; k < 12; k++) begin
      ctl = (k == 0) ? 7'h0C : (k == 1) ? 7'h7F : 7'($urandom);
      axi_wr(OFS_OUT_CTRL, {25'h0, ctl}, RESP_OKAY);
      repeat (700) @(posedge clk_sys);
      hi = 0;
      repeat (640) begin
        @(posedge clk_sys);
        if (line_end_out === 1'b1) hi++;
      end
      chk_bit(panel_power_out, ctl[3] & !ctl[5]);
      chk_bit(data_enable_out, !ctl[6]);
      chk_bit(hi > 0, ctl[2]);
      if (ctl[2]) chk_bit(hi > 320, ctl[4]);
      chk(panel_data, swp(mem_word, ctl[1:0]));
    end
    $display("Test output control and fetch done");
    lut = $urandom;
    axi_wr(OFS_OUT_CTRL, 32'h0, RESP_OKAY);
    axi_wr(OFS_RED_LUT, lut, RESP_OKAY);
    axi_wr(OFS_PANEL_CTRL, 32'h0000_0005, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      mem_word <= ($urandom & 32'hFFFF_FFF8) | 32'(c);
      repeat (700) @(posedge clk_sys);
      chk({28'h0, red_shade}, {28'h0, lut[c*4 +: 4]});
    end
    $display("Test red table done");
    // Dual scan: upper and lower lines alternate, LINES pairs a frame
    axi_wr(OFS_PANEL_CTRL, 32'h0, RESP_OKAY);
    repeat (60) @(posedge clk_sys);
    ptr = upper;
    ptl = lower;
    col = 0;
    ln = 0;
    half = 1'b0;
    dual = 1'b1;
    axi_wr(OFS_PANEL_CTRL, (32'(LINES - 1) << LINES_LSB) | 32'h0000_0003, RESP_OKAY);
    repeat (3000) @(posedge clk_sys);
    $display("Test dual scan done");
    complete_run();
  end
endmodule : test_lcd_frame_addr
